// File: drv_stat_pkg.sv
// Package for the driver status register bank: offsets, field positions, resets.
// Assumes a 16-bit register read port with 7-bit register addresses.
package drv_stat_pkg;
    localparam int          ADDR_W         = 7;
    localparam int          DATA_W         = 16;
    localparam int          NUM_SW         = 3;
    localparam int          NUM_BR         = 3;
    localparam int          NUM_PWM        = 6;
    localparam logic [6:0]  HS_FAULT_ADDR  = 7'h46;
    localparam logic [6:0]  BRIDGE_GENERAL_STATUS_ADDR  = 7'h50;
    localparam logic [15:0] STAT_RESET     = 16'h0000;
    localparam int          OT_LSB         = 10;
    localparam int          OL_LSB         = 5;
    localparam int          OC_LSB         = 0;
    localparam int          VOUT_LSB       = 6;
    localparam int          PWM_LSB        = 0;
    localparam logic [1:0]  MODE_SENSE     = 2'h3;
endpackage

// File: rc_flag.sv
// One read-to-clear sticky fault flag.
// Assumes the detect input is already synchronous to i_mclk.
`timescale 1ns/1ns
`default_nettype none
module rc_flag (
    input  wire logic i_mclk,
    input  wire logic i_rst,
    input  wire logic i_set,
    input  wire logic i_clr,
    output logic      o_flag
);
    // Set wins over clear so a fault during the read is kept
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            o_flag <= 1'b0;
        end else if (i_set) begin
            o_flag <= 1'b1;
        end else if (i_clr) begin
            o_flag <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// File: driver_status_registers.sv
// Two read-only status registers: high-side fault flags and bridge general status.
// Assumes fault detects and bridge mode/charge pump config are synchronous to i_mclk;
// pulse-width inputs and bridge comparator outputs are asynchronous pins.
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// - Overtemperature flags bits 12:10, clear on read
// - Open-load flags bits 7:5, clear on read
// - Overcurrent flags bits 2:0, clear on read
// - Reserved bits read zero, writes ignored
// - Bridge level bits 8:6 when mode 11, pump on
// - Bridge level reads zero otherwise
// - Bits 5:1 show pulse inputs six to two
// - Bit 0 shows pulse input one checksum pin
module driver_status_registers
    import drv_stat_pkg::*;
#(
    parameter int N_SW  = NUM_SW,
    parameter int N_BR  = NUM_BR,
    parameter int N_PWM = NUM_PWM
) (
    input  wire logic              i_mclk,
    input  wire logic              i_rst,
    input  wire logic              i_rd,
    input  wire logic              i_wr,
    input  wire logic [ADDR_W-1:0] i_addr,
    input  wire logic [DATA_W-1:0] i_wdata,
    input  wire logic [N_SW-1:0]   i_switch_overtemp,
    input  wire logic [N_SW-1:0]   i_switch_open_load,
    input  wire logic [N_SW-1:0]   i_switch_overcurrent,
    input  wire logic [N_BR-1:0]   i_bridge_output_node,
    input  wire logic [2*N_BR-1:0] i_bridge_mode_field,
    input  wire logic              i_charge_pump_enable,
    input  wire logic [N_PWM-1:0]  i_pulse_input,
    output logic [DATA_W-1:0]      o_rdata,
    output logic                   o_rvalid
);
    logic [N_SW-1:0]  ot_flag;
    logic [N_SW-1:0]  ol_flag;
    logic [N_SW-1:0]  oc_flag;
    logic [N_BR-1:0]  node_s1_q;
    logic [N_BR-1:0]  node_s2_q;
    logic [N_PWM-1:0] pwm_s1_q;
    logic [N_PWM-1:0] pwm_s2_q;
    logic [N_BR-1:0]  vout;
    logic             rd_fault;
    logic [DATA_W-1:0] fault_word;
    logic [DATA_W-1:0] gen_word;
    logic [DATA_W-1:0] rdata_d;

    // Bits that carry a field; everything else must read zero
    localparam logic [DATA_W-1:0] SW_ONES    = DATA_W'({N_SW{1'b1}});
    localparam logic [DATA_W-1:0] FAULT_MASK = (SW_ONES << OT_LSB) | (SW_ONES << OL_LSB)
                                             | (SW_ONES << OC_LSB);
    localparam logic [DATA_W-1:0] GEN_MASK   = (DATA_W'({N_BR{1'b1}}) << VOUT_LSB)
                                             | (DATA_W'({N_PWM{1'b1}}) << PWM_LSB);

    assign rd_fault = i_rd && (i_addr == HS_FAULT_ADDR);

    // Flags cleared only by reset or a read of their own register
    genvar g;
    generate
        for (g = 0; g < N_SW; g++) begin : g_sw
            rc_flag u_ot (.i_mclk(i_mclk), .i_rst(i_rst), .i_set(i_switch_overtemp[g]),
                          .i_clr(rd_fault), .o_flag(ot_flag[g]));
            rc_flag u_ol (.i_mclk(i_mclk), .i_rst(i_rst), .i_set(i_switch_open_load[g]),
                          .i_clr(rd_fault), .o_flag(ol_flag[g]));
            rc_flag u_oc (.i_mclk(i_mclk), .i_rst(i_rst), .i_set(i_switch_overcurrent[g]),
                          .i_clr(rd_fault), .o_flag(oc_flag[g]));
        end
    endgenerate

    // Pin levels pass two flops before any logic reads them
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            node_s1_q <= '0;
            node_s2_q <= '0;
            pwm_s1_q  <= '0;
            pwm_s2_q  <= '0;
        end else begin
            node_s1_q <= i_bridge_output_node;
            node_s2_q <= node_s1_q;
            pwm_s1_q  <= i_pulse_input;
            pwm_s2_q  <= pwm_s1_q;
        end
    end

    always_comb begin
        for (int b = 0; b < N_BR; b++) begin
            vout[b] = i_charge_pump_enable && (i_bridge_mode_field[2*b +: 2] == MODE_SENSE)
                      && node_s2_q[b];
        end
    end

    always_comb begin
        fault_word = STAT_RESET;
        fault_word[OT_LSB +: N_SW] = ot_flag;
        fault_word[OL_LSB +: N_SW] = ol_flag;
        fault_word[OC_LSB +: N_SW] = oc_flag;
        gen_word = STAT_RESET;
        gen_word[VOUT_LSB +: N_BR] = vout;
        gen_word[PWM_LSB +: N_PWM] = pwm_s2_q;
    end

    always_comb begin
        rdata_d = STAT_RESET;
        if (i_addr == HS_FAULT_ADDR) begin
            rdata_d = fault_word;
        end else if (i_addr == BRIDGE_GENERAL_STATUS_ADDR) begin
            rdata_d = gen_word;
        end
    end

    // Writes are accepted and dropped; both registers are read only
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            o_rdata  <= STAT_RESET;
            o_rvalid <= 1'b0;
        end else begin
            o_rvalid <= i_rd;
            if (i_rd) begin
                o_rdata <= rdata_d;
            end
        end
    end

    a_rd_clears_ot: assert property (@(posedge i_mclk) disable iff (i_rst)
        rd_fault && !i_switch_overtemp[0] |=> !ot_flag[0])
        else $error("overtemp flag not cleared by read");
    a_ot_sets: assert property (@(posedge i_mclk) disable iff (i_rst)
        i_switch_overtemp[1] |=> ot_flag[1])
        else $error("overtemp flag not set");
    a_ol_sets: assert property (@(posedge i_mclk) disable iff (i_rst)
        i_switch_open_load[2] |=> ol_flag[2])
        else $error("open-load flag not set");
    a_ol_clears: assert property (@(posedge i_mclk) disable iff (i_rst)
        rd_fault && !i_switch_open_load[2] |=> !ol_flag[2])
        else $error("open-load flag not cleared by read");
    a_oc_read_value: assert property (@(posedge i_mclk) disable iff (i_rst)
        rd_fault |=> o_rvalid && (o_rdata[OC_LSB +: N_SW] == $past(oc_flag)))
        else $error("overcurrent read value wrong");
    a_reserved_zero: assert property (@(posedge i_mclk) disable iff (i_rst)
        o_rvalid |-> (o_rdata[15:13] == 3'h0) && (o_rdata[9] == 1'b0))
        else $error("reserved bits nonzero");
    a_vout_gated: assert property (@(posedge i_mclk) disable iff (i_rst)
        i_rd && (i_addr == BRIDGE_GENERAL_STATUS_ADDR) && !i_charge_pump_enable |=> o_rdata[VOUT_LSB +: N_BR] == '0)
        else $error("bridge level not gated");
    a_vout_level: assert property (@(posedge i_mclk) disable iff (i_rst)
        i_rd && (i_addr == BRIDGE_GENERAL_STATUS_ADDR) && i_charge_pump_enable && (i_bridge_mode_field[1:0] == MODE_SENSE)
        |=> o_rdata[VOUT_LSB] == $past(node_s2_q[0]))
        else $error("bridge level wrong");
    a_pwm_level: assert property (@(posedge i_mclk) disable iff (i_rst)
        i_rd && (i_addr == BRIDGE_GENERAL_STATUS_ADDR) ##1 1'b1 |-> o_rdata[PWM_LSB +: N_PWM] == $past(pwm_s2_q))
        else $error("pulse level wrong");
    a_pwm1_pin: assert property (@(posedge i_mclk) disable iff (i_rst)
        !$past(i_rst) && !$past(i_rst, 2) && $past(i_pulse_input[0], 3) && $past(i_pulse_input[0], 2)
        && i_rd && (i_addr == BRIDGE_GENERAL_STATUS_ADDR)
        |=> o_rdata[PWM_LSB])
        else $error("checksum pin level wrong");
    a_set_beats_clr: assert property (@(posedge i_mclk) disable iff (i_rst)
        rd_fault && i_switch_overcurrent[0] |=> oc_flag[0])
        else $error("active fault lost on read");

    // Set and clear of the remaining flag kind, read values of the other two
    a_oc_sets: assert property (@(posedge i_mclk) disable iff (i_rst)
        i_switch_overcurrent[1] |=> oc_flag[1])
        else $error("overcurrent flag not set");
    a_oc_clears: assert property (@(posedge i_mclk) disable iff (i_rst)
        rd_fault && !i_switch_overcurrent[2] |=> !oc_flag[2])
        else $error("overcurrent flag not cleared by read");
    a_ot_read_value: assert property (@(posedge i_mclk) disable iff (i_rst)
        rd_fault |=> o_rvalid && (o_rdata[OT_LSB +: N_SW] == $past(ot_flag)))
        else $error("overtemp read value wrong");
    a_ol_read_value: assert property (@(posedge i_mclk) disable iff (i_rst)
        rd_fault |=> o_rvalid && (o_rdata[OL_LSB +: N_SW] == $past(ol_flag)))
        else $error("open-load read value wrong");

    // A flag only drops on a read of its own register
    for (genvar gs = 0; gs < N_SW; gs++) begin : g_sw_chk
        a_ot_holds: assert property (@(posedge i_mclk) disable iff (i_rst)
            !rd_fault |=> ot_flag[gs] || !$past(ot_flag[gs]))
            else $error("overtemp flag dropped without read");
        a_ol_holds: assert property (@(posedge i_mclk) disable iff (i_rst)
            !rd_fault |=> ol_flag[gs] || !$past(ol_flag[gs]))
            else $error("open-load flag dropped without read");
        a_oc_holds: assert property (@(posedge i_mclk) disable iff (i_rst)
            !rd_fault |=> oc_flag[gs] || !$past(oc_flag[gs]))
            else $error("overcurrent flag dropped without read");
    end

    // Reserved positions, unmapped reads and writes
    a_fault_rsvd: assert property (@(posedge i_mclk) disable iff (i_rst)
        rd_fault |=> (o_rdata & ~FAULT_MASK) == '0)
        else $error("fault register reserved bits nonzero");
    a_gen_rsvd: assert property (@(posedge i_mclk) disable iff (i_rst)
        i_rd && (i_addr == BRIDGE_GENERAL_STATUS_ADDR) |=> (o_rdata & ~GEN_MASK) == '0)
        else $error("general status reserved bits nonzero");
    a_unmapped_zero: assert property (@(posedge i_mclk) disable iff (i_rst)
        i_rd && (i_addr != HS_FAULT_ADDR) && (i_addr != BRIDGE_GENERAL_STATUS_ADDR)
        |=> o_rvalid && (o_rdata == STAT_RESET))
        else $error("unmapped read not zero");
    a_write_keeps: assert property (@(posedge i_mclk) disable iff (i_rst)
        i_wr && !rd_fault
        |=> ($past({ot_flag, ol_flag, oc_flag}) & ~{ot_flag, ol_flag, oc_flag}) == '0)
        else $error("write cleared a fault flag");
    a_write_silent: assert property (@(posedge i_mclk) disable iff (i_rst)
        i_wr && !i_rd |=> !o_rvalid && $stable(o_rdata))
        else $error("write changed read port");

    // Soft reset empties both registers and every flag
    a_reset_clears: assert property (@(posedge i_mclk)
        i_rst |=> !o_rvalid && (o_rdata == STAT_RESET)
        && (ot_flag == '0) && (ol_flag == '0) && (oc_flag == '0))
        else $error("reset did not clear the bank");

    // Pin level reaches the register two edges after the pin
    a_pin_sync_lat: assert property (@(posedge i_mclk) disable iff (i_rst)
        !$past(i_rst) |=> pwm_s2_q == $past(i_pulse_input, 2))
        else $error("pulse input sync latency wrong");
    a_node_sync_lat: assert property (@(posedge i_mclk) disable iff (i_rst)
        !$past(i_rst) |=> node_s2_q == $past(i_bridge_output_node, 2))
        else $error("bridge node sync latency wrong");

    // One pair of checks per bridge; gating inputs are used unsynchronised
    for (genvar gb = 0; gb < N_BR; gb++) begin : g_br_chk
        a_vout_follows: assert property (@(posedge i_mclk) disable iff (i_rst)
            i_rd && (i_addr == BRIDGE_GENERAL_STATUS_ADDR) && i_charge_pump_enable
            && (i_bridge_mode_field[2*gb +: 2] == MODE_SENSE)
            |=> o_rdata[VOUT_LSB + gb] == $past(node_s2_q[gb]))
            else $error("bridge level not reported");
        a_vout_mode_off: assert property (@(posedge i_mclk) disable iff (i_rst)
            i_rd && (i_addr == BRIDGE_GENERAL_STATUS_ADDR) && (i_bridge_mode_field[2*gb +: 2] != MODE_SENSE)
            |=> !o_rdata[VOUT_LSB + gb])
            else $error("bridge level shown outside sense mode");
    end
endmodule
`default_nettype wire

// File: tb_top.sv
// Self-checking bench for the driver status register bank; strobe reads and writes.
// Assumes drv_stat_pkg and the bank, with its own assertions, are compiled before it.
`timescale 1ns/1ns
`default_nettype none
module tb_top
    import drv_stat_pkg::*;
;
    logic        i_mclk = 1'b0;
    logic        i_rst  = 1'b1;
    logic        i_rd   = 1'b0;
    logic        i_wr   = 1'b0;
    logic        i_charge_pump_enable = 1'b0;
    logic [6:0]  i_addr  = 7'h00;
    logic [15:0] i_wdata = 16'h0000;
    logic [2:0]  ot = 3'h0, ol = 3'h0, oc = 3'h0, node = 3'h0;
    logic [5:0]  mode = 6'h00, pins = 6'h00;
    logic [15:0] o_rdata;
    logic        o_rvalid;
    int          failures = 0;
    int          n_checks = 0;

    always #5 i_mclk = ~i_mclk;

    driver_status_registers u_dut (
        .i_mclk(i_mclk), .i_rst(i_rst), .i_rd(i_rd), .i_wr(i_wr), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_switch_overtemp(ot), .i_switch_open_load(ol), .i_switch_overcurrent(oc),
        .i_bridge_output_node(node), .i_bridge_mode_field(mode),
        .i_charge_pump_enable(i_charge_pump_enable), .i_pulse_input(pins),
        .o_rdata(o_rdata), .o_rvalid(o_rvalid));

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
        n_checks++;
        if (s !== e) begin
            $display("mismatch %s expected %h seen %h", nm, e, s);
            failures++;
        end
    endtask

    task automatic results;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Answer comes exactly one edge after the strobe, so no polling loop
    task automatic rd(input logic [6:0] a, input logic [15:0] e);
        @(posedge i_mclk);
        i_rd   <= 1'b1;
        i_addr <= a;
        @(posedge i_mclk);
        i_rd <= 1'b0;
        #1;
        chk("rvalid", 16'h0001, {15'h0000, o_rvalid});
        chk("rdata", e, o_rdata);
    endtask

    // Write strobe lasts one edge; the bank must ignore it
    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        @(posedge i_mclk);
        i_wr    <= 1'b1;
        i_addr  <= a;
        i_wdata <= d;
        @(posedge i_mclk);
        i_wr <= 1'b0;
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge i_mclk);
    endtask

    initial begin
        #100000;
        failures++;
        $display("mismatch timeout expected finish seen hang");
        results();
    end

    initial begin
        idle(3);
        i_rst <= 1'b0;
        rd(HS_FAULT_ADDR, 16'h0000);
        rd(BRIDGE_GENERAL_STATUS_ADDR, 16'h0000);
        $display("test reset done");
        @(posedge i_mclk);
        {ot, ol, oc} <= {3'h7, 3'h5, 3'h2};
        @(posedge i_mclk);
        {ot, ol, oc} <= 9'h000;
        idle(1);
        rd(7'h47, 16'h0000);
        wr(HS_FAULT_ADDR, 16'h0000);
        rd(HS_FAULT_ADDR, 16'h1CA2);
        rd(HS_FAULT_ADDR, 16'h0000);
        wr(HS_FAULT_ADDR, 16'hFFFF);
        wr(BRIDGE_GENERAL_STATUS_ADDR, 16'hFFFF);
        rd(HS_FAULT_ADDR, 16'h0000);
        rd(BRIDGE_GENERAL_STATUS_ADDR, 16'h0000);
        $display("test fault flags done");
        @(posedge i_mclk);
        oc <= 3'h5;
        idle(1);
        rd(HS_FAULT_ADDR, 16'h0005);
        rd(HS_FAULT_ADDR, 16'h0005);
        @(posedge i_mclk);
        oc <= 3'h0;
        idle(1);
        rd(HS_FAULT_ADDR, 16'h0005);
        rd(HS_FAULT_ADDR, 16'h0000);
        $display("test active fault done");
        for (int k = 0; k < 2; k++) begin
            @(posedge i_mclk);
            pins <= (k == 0) ? 6'h2A : 6'h15;
            idle(3);
            rd(BRIDGE_GENERAL_STATUS_ADDR, (k == 0) ? 16'h002A : 16'h0015);
        end
        @(posedge i_mclk);
        pins <= 6'h00;
        node <= 3'h7;
        for (int p = 0; p < 2; p++) begin
            for (int m = 0; m < 4; m++) begin
                @(posedge i_mclk);
                i_charge_pump_enable <= p[0];
                mode                 <= {3{m[1:0]}};
                idle(3);
                rd(BRIDGE_GENERAL_STATUS_ADDR, (p == 1 && m == 3) ? 16'h01C0 : 16'h0000);
            end
        end
        @(posedge i_mclk);
        mode <= 6'h0C;
        idle(3);
        rd(BRIDGE_GENERAL_STATUS_ADDR, 16'h0080);
        @(posedge i_mclk);
        {node, mode} <= {3'h5, 6'h3F};
        idle(3);
        rd(BRIDGE_GENERAL_STATUS_ADDR, 16'h0140);
        $display("test general status done");
        @(posedge i_mclk);
        {ot, ol, oc} <= 9'h1FF;
        @(posedge i_mclk);
        {ot, ol, oc} <= 9'h000;
        i_rst        <= 1'b1;
        @(posedge i_mclk);
        #1;
        chk("rdata", 16'h0000, o_rdata);
        chk("rvalid", 16'h0000, {15'h0000, o_rvalid});
        idle(2);
        i_rst <= 1'b0;
        rd(HS_FAULT_ADDR, 16'h0000);
        rd(BRIDGE_GENERAL_STATUS_ADDR, 16'h0140);
        $display("test mid reset done");
        results();
    end
endmodule
`default_nettype wire
